// [src/crpc_map.svh]
// Register offsets, field positions, reset values and timing counts of the reset/power block.
`ifndef CRPC_MAP_SVH
`define CRPC_MAP_SVH
`define CRPC_OFS_SOFT_RST     16'h8810
`define CRPC_OFS_PD_CTRL      16'h8812
`define CRPC_OFS_PHY_RST      16'h8814
`define CRPC_OFS_MACIF_RST    16'h8815
`define CRPC_OFS_STATE        16'h8818
`define CRPC_OFS_PMG_CTRL     16'h8819
`define CRPC_OFS_DIAG_CLK     16'h882c
`define CRPC_BIT_RESET        0
`define CRPC_BIT_PD           0
`define CRPC_BIT_READY        0
`define CRPC_BIT_PD_REACHED   1
`define CRPC_BIT_OSC          0
`define CRPC_BIT_DIAG_EN      0
`define CRPC_RST_DIAG_CLK     16'h0002
`define CRPC_RST_ZERO         16'h0000
`define CRPC_STARTUP_NS       1000
`define CRPC_STARTUP_CYC      ((`CRPC_STARTUP_NS + 9) / 10)
`define CRPC_SUBRST_NS        160
`define CRPC_SUBRST_CYC       ((`CRPC_SUBRST_NS + 9) / 10)
`define CRPC_CHIPRST_NS       320
`define CRPC_CHIPRST_CYC      ((`CRPC_CHIPRST_NS + 9) / 10)
`endif

// [src/crpc_pkg.sv]
// Types shared by the reset and power control block.
package crpc_pkg;
  typedef enum logic [3:0] {
    CRPC_ST_CHIPRST = 4'h1,
    CRPC_ST_STARTUP = 4'h2,
    CRPC_ST_RUN     = 4'h4,
    CRPC_ST_PDOWN   = 4'h8
  } crpc_state_t;
endpackage

// [src/crpc_pulse_stretch.sv]
// Self-clearing reset bit that holds its reset output for a fixed cycle count.
`include "crpc_map.svh"
module crpc_pulse_stretch #(
  parameter int unsigned CYCLES = 16
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Trigger and result
  input  wire logic start,
  output logic      active
);
  logic [7:0] countReg;
  logic [7:0] countNext;
  logic       activeNext;

  assign countNext  = start ? CYCLES[7:0] : (countReg != 8'h00 ? countReg - 8'h01 : 8'h00);
  assign activeNext = (countNext != 8'h00);

  always_ff @(posedge clk) begin
    if (reset) begin
      countReg <= 8'h00;
      active   <= 1'b0;
    end else begin
      countReg <= countNext;
      active   <= activeNext;
    end
  end
endmodule

// [src/crpc_chip_reset_power.sv]
// Chip-level software reset and power management registers on the management bus.
//
// Function
// - Full-chip soft reset reinitialises, then self-clears.
// - Soft power-down turns off most circuitry.
// - Registers stay accessible during power-down.
// - Power-down reset value taken from strap pin.
// - PHY subsystem reset bit, self-clearing.
// - MAC interface reset bit, self-clearing.
// - Status bit 1 shows power-down state.
// - Status bit 0 shows start-up complete.
// - Force boot oscillator enable, resets zero.
// - Diagnostics clock enable bit 0, reset 0x0002.
`include "crpc_map.svh"
module crpc_chip_reset_power (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Management register port
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [15:0] regAddr,
  input  wire logic [15:0] regWdata,
  output logic      [15:0] regRdata,
  output logic             regRvalid,
  // Strap pin
  input  wire logic        powerDownStrapPin,
  // Controls to the chip
  output logic             chipResetOut,
  output logic             phySubsystemResetOut,
  output logic             macInterfaceResetOut,
  output logic             circuitryPowerDown,
  output logic             forceBootOscEnable,
  output logic             diagnosticsClockEnable
);
  crpc_pkg::crpc_state_t stateReg;
  crpc_pkg::crpc_state_t stateNext;
  logic [2:0]  strapSync;
  logic        strapValue;
  logic        strapLoad_reg;
  logic        strapSeen_reg;
  logic        softPowerDown_reg;
  logic        softPowerDown_next;
  logic        forceOsc_reg;
  logic        diagEn_reg;
  logic [15:0] startCount_reg;
  logic [15:0] startCount_next;
  logic [7:0]  chipCount_reg;
  logic [7:0]  chipCount_next;
  logic        phyActive;
  logic        macActive;
  logic        internalReset;
  logic [15:0] readMux;

  wire selSoft  = (regAddr == `CRPC_OFS_SOFT_RST);
  wire selPd    = (regAddr == `CRPC_OFS_PD_CTRL);
  wire selPhy   = (regAddr == `CRPC_OFS_PHY_RST);
  wire selMac   = (regAddr == `CRPC_OFS_MACIF_RST);
  wire selState = (regAddr == `CRPC_OFS_STATE);
  wire selPmg   = (regAddr == `CRPC_OFS_PMG_CTRL);
  wire selDiag  = (regAddr == `CRPC_OFS_DIAG_CLK);

  wire chipRstReq = regWrite && selSoft && regWdata[`CRPC_BIT_RESET];
  wire phyRstReq  = regWrite && selPhy && regWdata[`CRPC_BIT_RESET] && !internalReset;
  wire macRstReq  = regWrite && selMac && regWdata[`CRPC_BIT_RESET] && !internalReset;

  // Soft reset clears the oscillator, diagnostics and sub-reset registers; the power-down bit and strap capture keep their values.
  assign internalReset = reset || (stateReg == crpc_pkg::CRPC_ST_CHIPRST);

  assign strapValue = strapSync[2];
  // Apart from the load right after reset, a one-cycle glitch on the strap never reaches the power-down bit.
  wire strapAgree = (strapSync[2] == strapSync[1]);

  assign softPowerDown_next = strapLoad_reg ? strapValue :
                              (regWrite && selPd) ? regWdata[`CRPC_BIT_PD] : softPowerDown_reg;

  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      crpc_pkg::CRPC_ST_CHIPRST: if (chipCount_reg == 8'h00) stateNext = crpc_pkg::CRPC_ST_STARTUP;
      crpc_pkg::CRPC_ST_STARTUP: begin
        // Going straight to power-down keeps ready from flashing high for one cycle.
        if (startCount_reg == 16'h0000) begin
          stateNext = softPowerDown_reg ? crpc_pkg::CRPC_ST_PDOWN : crpc_pkg::CRPC_ST_RUN;
        end
      end
      crpc_pkg::CRPC_ST_RUN:     if (softPowerDown_reg) stateNext = crpc_pkg::CRPC_ST_PDOWN;
      crpc_pkg::CRPC_ST_PDOWN:   if (!softPowerDown_reg) stateNext = crpc_pkg::CRPC_ST_STARTUP;
      default:                   stateNext = crpc_pkg::CRPC_ST_CHIPRST;
    endcase
    if (chipRstReq) begin
      stateNext = crpc_pkg::CRPC_ST_CHIPRST;
    end
  end

  assign chipCount_next  = chipRstReq ? 8'((`CRPC_CHIPRST_CYC) - 1) :
                           (chipCount_reg != 8'h00 ? chipCount_reg - 8'h01 : 8'h00);
  assign startCount_next = (stateNext == crpc_pkg::CRPC_ST_STARTUP &&
                            stateReg != crpc_pkg::CRPC_ST_STARTUP) ? 16'((`CRPC_STARTUP_CYC) - 1) :
                           (startCount_reg != 16'h0000 ? startCount_reg - 16'h0001 : 16'h0000);

  wire statusReady     = (stateReg == crpc_pkg::CRPC_ST_RUN);
  wire statusPowerDown = (stateReg == crpc_pkg::CRPC_ST_PDOWN);

  assign readMux = selSoft  ? {15'h0000, stateReg == crpc_pkg::CRPC_ST_CHIPRST} :
                   selPd    ? {15'h0000, softPowerDown_reg} :
                   selPhy   ? {15'h0000, phyActive} :
                   selMac   ? {15'h0000, macActive} :
                   selState ? {14'h0000, statusPowerDown, statusReady} :
                   selPmg   ? {15'h0000, forceOsc_reg} :
                   selDiag  ? (`CRPC_RST_DIAG_CLK | {15'h0000, diagEn_reg}) :
                   16'h0000;

  always_ff @(posedge clk) begin
    strapSync <= {strapSync[1:0], powerDownStrapPin};
    if (strapAgree) strapSeen_reg <= strapSync[2];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      stateReg       <= crpc_pkg::CRPC_ST_STARTUP;
      chipCount_reg  <= 8'h00;
      startCount_reg <= 16'((`CRPC_STARTUP_CYC) - 1);
      strapLoad_reg  <= 1'b1;
    end else begin
      stateReg       <= stateNext;
      chipCount_reg  <= chipCount_next;
      startCount_reg <= startCount_next;
      strapLoad_reg  <= strapAgree && (strapSync[2] != strapSeen_reg);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      softPowerDown_reg <= 1'b0;
    end else begin
      softPowerDown_reg <= softPowerDown_next;
    end
  end

  always_ff @(posedge clk) begin
    if (internalReset) begin
      forceOsc_reg <= 1'b0;
      diagEn_reg   <= 1'b0;
    end else begin
      if (regWrite && selPmg) forceOsc_reg <= regWdata[`CRPC_BIT_OSC];
      if (regWrite && selDiag) diagEn_reg <= regWdata[`CRPC_BIT_DIAG_EN];
    end
  end

  crpc_pulse_stretch #(.CYCLES(`CRPC_SUBRST_CYC)) phyStretch (
    .clk    (clk),
    .reset  (internalReset),
    .start  (phyRstReq),
    .active (phyActive)
  );

  crpc_pulse_stretch #(.CYCLES(`CRPC_SUBRST_CYC)) macStretch (
    .clk    (clk),
    .reset  (internalReset),
    .start  (macRstReq),
    .active (macActive)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      regRdata               <= 16'h0000;
      regRvalid              <= 1'b0;
      chipResetOut           <= 1'b0;
      phySubsystemResetOut   <= 1'b0;
      macInterfaceResetOut   <= 1'b0;
      circuitryPowerDown     <= 1'b0;
      forceBootOscEnable     <= 1'b0;
      diagnosticsClockEnable <= 1'b0;
    end else begin
      regRdata               <= regRead ? readMux : 16'h0000;
      regRvalid              <= regRead;
      chipResetOut           <= (stateNext == crpc_pkg::CRPC_ST_CHIPRST);
      phySubsystemResetOut   <= phyActive;
      macInterfaceResetOut   <= macActive;
      circuitryPowerDown     <= softPowerDown_next;
      forceBootOscEnable     <= forceOsc_reg;
      diagnosticsClockEnable <= diagEn_reg;
    end
  end

  // Power-down must follow the control bit within one cycle.
  chk_pd_follow: assert property (@(posedge clk) disable iff (reset)
    !strapLoad_reg |=> circuitryPowerDown == $past(softPowerDown_next))
    else $error("power-down output does not follow control bit");

  chk_pd_enter: assert property (@(posedge clk) disable iff (reset)
    (softPowerDown_reg && stateReg == crpc_pkg::CRPC_ST_RUN && !chipRstReq) |=>
    stateReg == crpc_pkg::CRPC_ST_PDOWN)
    else $error("power-down state not entered");

  chk_ready_run: assert property (@(posedge clk) disable iff (reset)
    (stateReg == crpc_pkg::CRPC_ST_STARTUP) |-> !(readMux[0] && selState))
    else $error("ready reads one during start-up");

  chk_pd_status: assert property (@(posedge clk) disable iff (reset)
    selState |-> readMux[1] == (stateReg == crpc_pkg::CRPC_ST_PDOWN))
    else $error("power-down status wrong");

  chk_chip_reset: assert property (@(posedge clk) disable iff (reset)
    chipRstReq |=> chipResetOut ##1 chipResetOut)
    else $error("chip reset not started");

  chk_phy_sc: assert property (@(posedge clk) disable iff (internalReset)
    phyRstReq |=> phyActive [*8])
    else $error("phy reset not held");

  chk_mac_sc: assert property (@(posedge clk) disable iff (internalReset)
    macRstReq |=> macActive ##[1:20] !macActive)
    else $error("mac reset did not clear");

  chk_read_pd: assert property (@(posedge clk) disable iff (reset)
    regRead |=> regRvalid)
    else $error("read lost");

  chk_zero_noop: assert property (@(posedge clk) disable iff (internalReset)
    (regWrite && selPhy && !regWdata[0] && !phyActive) |=> !phyActive)
    else $error("zero write started reset");

  chk_diag_reserved: assert property (@(posedge clk) disable iff (reset)
    selDiag |-> readMux[1] && readMux[0] == diagEn_reg)
    else $error("diag clock register wrong");

  chk_osc_write: assert property (@(posedge clk) disable iff (internalReset)
    (regWrite && selPmg) |=> forceOsc_reg == $past(regWdata[0]))
    else $error("oscillator bit not written");
endmodule

// [testbench/crpc_mgmt_host.sv]
// Management host model that issues single register reads and writes.
module crpc_mgmt_host (
  // Clock
  input  wire logic        clk,
  // Register port
  output logic             regWrite,
  output logic             regRead,
  output logic      [15:0] regAddr,
  output logic      [15:0] regWdata,
  input  wire logic [15:0] regRdata,
  input  wire logic        regRvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 16'h0000;
    regWdata = 16'h0000;
  end
  // Released address and data are inverted so that a stale value can never pass for a good one.
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge clk);
    regWrite = 1'b0;
    regAddr = ~a;
    regWdata = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] q);
    @(negedge clk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clk);
    regRead = 1'b0;
    regAddr = ~a;
    q = regRvalid ? regRdata : 16'hxxxx;
  endtask
endmodule

// [testbench/crpc_chip_reset_power_tb.sv]
// Testbench for the reset and power control block against a register model.
module crpc_chip_reset_power_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        powerDownStrapPin = 1'b1;
  logic        regWrite, regRead, regRvalid, chipRst, phyRst, macRst, pDown, oscEn, diagEn;
  logic [15:0] regAddr, regWdata, regRdata, q, rnd;
  logic [15:0] m [int];
  logic [15:0] addrs [6] = '{16'h8810, 16'h8812, 16'h8814, 16'h8815, 16'h8819, 16'h882c};
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          cycles = 0;
  always #5 clk = ~clk;
  crpc_mgmt_host crpc_mgmt_host_inst (.clk(clk), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid));
  crpc_chip_reset_power crpc_chip_reset_power_inst (.clk(clk), .reset(reset),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .regRvalid(regRvalid), .powerDownStrapPin(powerDownStrapPin),
    .chipResetOut(chipRst), .phySubsystemResetOut(phyRst), .macInterfaceResetOut(macRst),
    .circuitryPowerDown(pDown), .forceBootOscEnable(oscEn), .diagnosticsClockEnable(diagEn));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Only bit 0 is writable; the diagnostics register keeps its fixed bit 1.
  task automatic w(input logic [15:0] a, input logic [15:0] d);
    crpc_mgmt_host_inst.wr(a, d);
    if (a == 16'h8812 || a == 16'h8819) m[a] = d & 16'h0001;
    if (a == 16'h882c) m[a] = 16'h0002 | (d & 16'h0001);
  endtask
  task automatic r(input logic [15:0] a);
    crpc_mgmt_host_inst.rd(a, q);
    check(q, m.exists(a) ? m[a] : 16'h0000);
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      print_verdict;
    end
  end
  initial begin
    void'($urandom(49273));
    m[16'h8812] = 16'h0001;
    m[16'h8818] = 16'h0000;
    m[16'h8819] = 16'h0000;
    m[16'h882c] = 16'h0002;
    repeat (20) @(negedge clk);
    reset = 1'b0;
    r(16'h8818);
    repeat (4) @(negedge clk);
    foreach (addrs[i]) r(addrs[i]);
    check(16'(pDown), 16'h0001);
    repeat (120) @(negedge clk);
    m[16'h8818] = 16'h0002;
    r(16'h8818);
    // Writes still land while the chip is powered down.
    w(16'h8819, 16'hffff);
    r(16'h8819);
    check(16'(oscEn), 16'h0001);
    powerDownStrapPin = 1'b0;
    w(16'h8812, 16'h0000);
    m[16'h8818] = 16'h0000;
    repeat (3) @(negedge clk);
    r(16'h8818);
    check(16'(pDown), 16'h0000);
    repeat (110) @(negedge clk);
    m[16'h8818] = 16'h0001;
    r(16'h8818);
    // Power-down by register write from the running state.
    w(16'h8812, 16'h0001);
    m[16'h8818] = 16'h0002;
    r(16'h8818);
    check(16'(pDown), 16'h0001);
    w(16'h8812, 16'h0000);
    m[16'h8818] = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      rnd = 16'($urandom);
      w(16'h882c, rnd);
      r(16'h882c);
      check(16'(diagEn), 16'(rnd[0]));
    end
    rnd = {4'h9, 12'($urandom)};
    w(rnd, 16'hffff);
    r(rnd);
    // Each sub-reset must leave the other one alone.
    for (int i = 0; i < 2; i++) begin
      rnd = i ? 16'h8815 : 16'h8814;
      w(rnd, 16'hfffe);
      check({14'h0, phyRst, macRst}, 16'h0000);
      r(rnd);
      w(rnd, 16'h0001);
      // The reset output follows its bit by one registered stage.
      @(negedge clk);
      check({14'h0, phyRst, macRst}, i ? 16'h0001 : 16'h0002);
      crpc_mgmt_host_inst.rd(rnd, q);
      check(q, 16'h0001);
      repeat (20) @(negedge clk);
      check({14'h0, phyRst, macRst}, 16'h0000);
      r(rnd);
    end
    // Full chip reset clears the oscillator and diagnostics bits and reruns start-up.
    w(16'h8810, 16'h0001);
    m[16'h8819] = 16'h0000;
    m[16'h882c] = 16'h0002;
    m[16'h8818] = 16'h0000;
    check(16'(chipRst), 16'h0001);
    repeat (40) @(negedge clk);
    check({13'h0, chipRst, oscEn, diagEn}, 16'h0000);
    r(16'h8810);
    r(16'h8818);
    r(16'h8819);
    r(16'h882c);
    repeat (110) @(negedge clk);
    m[16'h8818] = 16'h0001;
    r(16'h8818);
    print_verdict;
  end
endmodule
